// [design/iec_pkg.sv]
// Constants, register map and carrier types of the interrupt enable control block.
// Operation
// - Global enable set passes every active interrupt; cleared blocks all from the core.
// - Peripheral-group enable set passes peripheral interrupts; cleared blocks them all.
// - Edge select one picks rising edge of external pin, zero falling edge.
// - Edge select resets to one; global and peripheral-group enables reset to zero.
// - Control register bits five down to one are unimplemented and read zero.
// - Source flags are set by events regardless of any enable bit.
// - Sources with enables in peripheral enable registers need the group enable.
// - Enable register zero: timer-zero bit 5, change detect bit 4, pin bit 0.
// - Enable register one holds eight enables, timer-one gate down to timer-one overflow.
// - Enable register two: comparator b, comparator a, nvm done, oscillator rollover.
// - On the small variant comparator b is absent, so its enable gates nothing.
// - Enable register three: oscillator fail, clock switch, logic cells b and a.
// - All implemented per-source enable bits reset to zero on every reset.
// - Taking an enabled interrupt clears global enable and jumps to vector 0004h.
// - External pin flag sets on each valid edge of the selected polarity.
// - Return from interrupt sets the global enable again.
package iec_pkg;

  // ----------------------------------------------------------------
  // Register offsets, byte addresses on the APB.
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_EN0 = 8'h04;
  localparam logic [7:0] OFF_EN1 = 8'h08;
  localparam logic [7:0] OFF_EN2 = 8'h0c;
  localparam logic [7:0] OFF_EN3 = 8'h10;
  localparam logic [7:0] OFF_FLAG0 = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_MASK = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and implemented-bit masks.
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_GIE_BIT = 7;
  localparam int unsigned CTRL_PERIPHERAL_GROUP_ENABLE_BIT = 6;
  localparam int unsigned CTRL_EDGE_BIT = 0;
  localparam int unsigned EN0_EXT_BIT = 0;
  localparam int unsigned EN2_CMPB_BIT = 6;
  localparam logic [7:0] EN0_IMPL = 8'h31;
  localparam logic [7:0] EN1_IMPL = 8'hff;
  localparam logic [7:0] EN2_IMPL = 8'h71;
  localparam logic [7:0] EN3_IMPL = 8'hc3;

  // ----------------------------------------------------------------
  // Reset values.
  // ----------------------------------------------------------------
  localparam logic RST_GIE = 1'b0;
  localparam logic RST_PERIPHERAL_GROUP_ENABLE = 1'b0;
  localparam logic RST_EDGE = 1'b1;
  localparam logic [7:0] RST_EN = 8'h00;
  localparam logic [2:0] RST_STAT_MASK = 3'h0;

  // ----------------------------------------------------------------
  // Event status bits and the vector.
  // ----------------------------------------------------------------
  localparam int unsigned ST_EXT_EDGE = 0;
  localparam int unsigned ST_TAKEN = 1;
  localparam int unsigned ST_RETURN = 2;
  localparam int unsigned ST_W = 3;
  localparam logic [15:0] VECTOR_ADDR = 16'h0004;
  localparam int unsigned SYNC_PRIME = 3;

  // Four flag or enable bytes laid out like the four enable registers.
  typedef struct packed {
    logic [7:0] r3;
    logic [7:0] r2;
    logic [7:0] r1;
    logic [7:0] r0;
  } iec_bank_t;

endpackage

// [design/iec_flag_cell.sv]
// Sticky flag bit where a set in the clearing cycle wins.
`timescale 1ns/1ps
module iec_flag_cell (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_q
);

  logic next_q;

  assign next_q = i_set | (o_q & ~i_clr);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_q <= 1'b0;
    end else begin
      o_q <= next_q;
    end
  end

endmodule

// [design/iec_edge_sync.sv]
// Two-stage synchroniser and selectable edge detector for the external pin.
`timescale 1ns/1ps
module iec_edge_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_rising,
  output logic o_edge
);

  logic meta;
  logic sync;
  logic prev;
  logic [1:0] prime;
  logic primed;

  // No edge is reported until the chain holds real pin samples, so a pin
  // that sits high through reset does not look like a rising edge.
  // The previous-sample stage only holds a real sample after the third edge.
  assign primed = (prime == 2'(iec_pkg::SYNC_PRIME));
  assign o_edge = primed & (i_rising ? (sync & ~prev) : (~sync & prev));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
      prime <= 2'h0;
    end else begin
      meta <= i_pin;
      sync <= meta;
      prev <= sync;
      prime <= primed ? prime : prime + 2'h1;
    end
  end

endmodule

// [design/iec_ctrl.sv]
// Interrupt enable control: APB registers, request gating and vector request.
`timescale 1ns/1ps
module iec_ctrl #(
  parameter bit HAS_COMPARATOR_B = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire iec_pkg::iec_bank_t i_src_flags,
  input wire logic i_ext_pin,
  input wire logic i_return_from_irq,
  output logic o_core_irq,
  output logic [15:0] o_vector_addr,
  output logic o_wake_req,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------
  logic global_irq_enable;
  logic peripheral_group_enable;
  logic ext_edge_select;
  iec_pkg::iec_bank_t enable_bank;
  logic [iec_pkg::ST_W-1:0] stat_mask;
  logic [iec_pkg::ST_W-1:0] stat_q;
  logic ext_pin_irq_flag;

  // ----------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------
  logic access;
  logic wr_en;
  logic rd_en;
  logic lane0;
  logic hit_ctrl;
  logic hit_en0;
  logic hit_en1;
  logic hit_en2;
  logic hit_en3;
  logic hit_flag0;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic [7:0] wbyte;

  // The slave inserts one wait state; the write lands on the completing edge.
  assign access = i_psel & i_penable;
  assign wr_en = access & o_pready & i_pwrite & lane0 & mapped;
  assign rd_en = access & ~o_pready & ~i_pwrite;
  assign lane0 = i_pstrb[0];
  assign wbyte = i_pwdata[7:0];
  assign hit_ctrl = (i_paddr == iec_pkg::OFF_CTRL);
  assign hit_en0 = (i_paddr == iec_pkg::OFF_EN0);
  assign hit_en1 = (i_paddr == iec_pkg::OFF_EN1);
  assign hit_en2 = (i_paddr == iec_pkg::OFF_EN2);
  assign hit_en3 = (i_paddr == iec_pkg::OFF_EN3);
  assign hit_flag0 = (i_paddr == iec_pkg::OFF_FLAG0);
  assign hit_status = (i_paddr == iec_pkg::OFF_STATUS);
  assign hit_mask = (i_paddr == iec_pkg::OFF_MASK);
  assign mapped = hit_ctrl | hit_en0 | hit_en1 | hit_en2 | hit_en3 | hit_flag0 |
                  hit_status | hit_mask;

  // ----------------------------------------------------------------
  // Flag bank seen by the gating logic.
  // ----------------------------------------------------------------
  logic ext_edge;
  logic [7:0] flag_r0;
  logic [7:0] flag_r2;
  iec_pkg::iec_bank_t flag_bank;
  iec_pkg::iec_bank_t active;
  logic any_active;
  logic pending;
  logic take;

  iec_edge_sync u_edge (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_pin),
    .i_rising(ext_edge_select),
    .o_edge(ext_edge)
  );

  // The pin flag is set by any valid edge whatever the enables say, and a
  // write of one clears it unless an edge arrives in the same cycle.
  iec_flag_cell u_ext_flag (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_set(ext_edge),
    .i_clr(wr_en & hit_flag0 & wbyte[iec_pkg::EN0_EXT_BIT]),
    .o_q(ext_pin_irq_flag)
  );

  // Peripheral flags arrive already set by their sources, unaffected by any
  // enable here; only the pin flag is held locally.
  assign flag_r0 = {i_src_flags.r0[7:1], ext_pin_irq_flag} & iec_pkg::EN0_IMPL;
  // The small variant has no second comparator, so that flag is forced low.
  assign flag_r2 = HAS_COMPARATOR_B ? i_src_flags.r2 :
                   (i_src_flags.r2 & ~(8'h01 << iec_pkg::EN2_CMPB_BIT));
  assign flag_bank.r0 = flag_r0;
  assign flag_bank.r1 = i_src_flags.r1 & iec_pkg::EN1_IMPL;
  assign flag_bank.r2 = flag_r2 & iec_pkg::EN2_IMPL;
  assign flag_bank.r3 = i_src_flags.r3 & iec_pkg::EN3_IMPL;

  assign active = flag_bank & enable_bank;
  assign any_active = |active;
  // Every source has its enable in one of the four peripheral enable
  // registers, so each one also needs the group enable.
  assign pending = peripheral_group_enable & any_active;
  assign take = global_irq_enable & pending;

  // ----------------------------------------------------------------
  // Interrupt control register.
  // ----------------------------------------------------------------
  logic wr_ctrl;
  logic next_gie;
  logic next_peripheral_group_enable;
  logic next_edge_sel;

  assign wr_ctrl = wr_en & hit_ctrl;
  // Taking the vector clears the global enable; the return sets it back.
  // Hardware wins over a software write in the same cycle.
  assign next_gie = take ? 1'b0 :
                    i_return_from_irq ? 1'b1 :
                    wr_ctrl ? wbyte[iec_pkg::CTRL_GIE_BIT] : global_irq_enable;
  assign next_peripheral_group_enable = wr_ctrl ? wbyte[iec_pkg::CTRL_PERIPHERAL_GROUP_ENABLE_BIT] : peripheral_group_enable;
  assign next_edge_sel = wr_ctrl ? wbyte[iec_pkg::CTRL_EDGE_BIT] : ext_edge_select;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      global_irq_enable <= iec_pkg::RST_GIE;
      peripheral_group_enable <= iec_pkg::RST_PERIPHERAL_GROUP_ENABLE;
      ext_edge_select <= iec_pkg::RST_EDGE;
    end else begin
      global_irq_enable <= next_gie;
      peripheral_group_enable <= next_peripheral_group_enable;
      ext_edge_select <= next_edge_sel;
    end
  end

  // ----------------------------------------------------------------
  // Peripheral enable registers.
  // ----------------------------------------------------------------
  iec_pkg::iec_bank_t next_enable;

  // Unimplemented positions are masked on write so they always read zero.
  assign next_enable.r0 = (wr_en & hit_en0) ? (wbyte & iec_pkg::EN0_IMPL) :
                          enable_bank.r0;
  assign next_enable.r1 = (wr_en & hit_en1) ? (wbyte & iec_pkg::EN1_IMPL) :
                          enable_bank.r1;
  assign next_enable.r2 = (wr_en & hit_en2) ? (wbyte & iec_pkg::EN2_IMPL) :
                          enable_bank.r2;
  assign next_enable.r3 = (wr_en & hit_en3) ? (wbyte & iec_pkg::EN3_IMPL) :
                          enable_bank.r3;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_bank.r0 <= iec_pkg::RST_EN;
      enable_bank.r1 <= iec_pkg::RST_EN;
      enable_bank.r2 <= iec_pkg::RST_EN;
      enable_bank.r3 <= iec_pkg::RST_EN;
    end else begin
      enable_bank <= next_enable;
    end
  end

  // ----------------------------------------------------------------
  // Event status, mask and interrupt line.
  // ----------------------------------------------------------------
  logic [iec_pkg::ST_W-1:0] stat_set;
  logic [iec_pkg::ST_W-1:0] stat_clr;
  logic [iec_pkg::ST_W-1:0] next_mask;
  logic next_irq;

  assign stat_set[iec_pkg::ST_EXT_EDGE] = ext_edge;
  assign stat_set[iec_pkg::ST_TAKEN] = take;
  assign stat_set[iec_pkg::ST_RETURN] = i_return_from_irq;
  assign stat_clr = (wr_en & hit_status) ? wbyte[iec_pkg::ST_W-1:0] : '0;
  assign next_mask = (wr_en & hit_mask) ? wbyte[iec_pkg::ST_W-1:0] : stat_mask;
  assign next_irq = |(stat_q & stat_mask);

  for (genvar g = 0; g < iec_pkg::ST_W; g++) begin : g_stat
    iec_flag_cell u_cell (
      .i_clk(i_clk),
      .i_rst_n(i_rst_n),
      .i_set(stat_set[g]),
      .i_clr(stat_clr[g]),
      .o_q(stat_q[g])
    );
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stat_mask <= iec_pkg::RST_STAT_MASK;
      o_irq <= 1'b0;
    end else begin
      stat_mask <= next_mask;
      o_irq <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // Core-facing outputs.
  // ----------------------------------------------------------------
  // The core request rises for one cycle: taking it drops the global enable,
  // so a flag left set cannot re-enter until the return.
  logic [15:0] next_vector;

  assign next_vector = take ? iec_pkg::VECTOR_ADDR : o_vector_addr;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_core_irq <= 1'b0;
      o_vector_addr <= 16'h0000;
      o_wake_req <= 1'b0;
    end else begin
      o_core_irq <= take;
      o_vector_addr <= next_vector;
      o_wake_req <= pending;
    end
  end

  // ----------------------------------------------------------------
  // Read data and APB answer.
  // ----------------------------------------------------------------
  logic [7:0] ctrl_rd;
  logic [7:0] status_rd;
  logic [7:0] mask_rd;
  logic [7:0] rd_byte;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;

  assign ctrl_rd = {global_irq_enable, peripheral_group_enable, 5'h00,
                    ext_edge_select};
  assign status_rd = {5'h00, stat_q};
  assign mask_rd = {5'h00, stat_mask};
  assign rd_byte = hit_ctrl ? ctrl_rd :
                   hit_en0 ? enable_bank.r0 :
                   hit_en1 ? enable_bank.r1 :
                   hit_en2 ? enable_bank.r2 :
                   hit_en3 ? enable_bank.r3 :
                   hit_flag0 ? flag_bank.r0 :
                   hit_status ? status_rd :
                   hit_mask ? mask_rd : 8'h00;
  assign next_prdata = rd_en ? {24'h000000, rd_byte} : o_prdata;
  assign next_pready = access & ~o_pready;
  assign next_pslverr = access & ~o_pready & ~mapped;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h00000000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_prdata <= next_prdata;
      o_pready <= next_pready;
      o_pslverr <= next_pslverr;
    end
  end

endmodule

// [bench/iec_ctrl_monitor.sv]
// Concurrent checks on the ports of the interrupt enable control block.
`timescale 1ns/1ps
module iec_ctrl_monitor (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic i_return_from_irq,
  input wire logic o_core_irq,
  input wire logic [15:0] o_vector_addr,
  input wire logic o_wake_req,
  input wire logic o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  wire logic done = o_pready && i_psel && i_penable;
  wire logic rd_done = done && !i_pwrite;
  wire logic wr_ctrl = done && i_pwrite && i_paddr == iec_pkg::OFF_CTRL && i_pstrb[0];
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_wait;
    i_psel && !i_penable |=> !o_pready ##1 o_pready;
  endproperty
  a_wait: assert property (p_wait) else $error("ready not after one wait state");
  property p_ctrl_rd;
    rd_done && i_paddr == iec_pkg::OFF_CTRL |-> o_prdata[31:1] == 31'h0 || o_prdata[5:1] == 5'h0
      && o_prdata[31:8] == 24'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("control hole bits not zero");
  property p_en0_rd;
    rd_done && i_paddr == iec_pkg::OFF_EN0 |-> (o_prdata & ~{24'h0, iec_pkg::EN0_IMPL}) == 0;
  endproperty
  a_en0_rd: assert property (p_en0_rd) else $error("enable 0 hole bits set");
  property p_en2_rd;
    rd_done && i_paddr == iec_pkg::OFF_EN2 |-> (o_prdata & ~{24'h0, iec_pkg::EN2_IMPL}) == 0;
  endproperty
  a_en2_rd: assert property (p_en2_rd) else $error("enable 2 hole bits set");
  property p_en3_rd;
    rd_done && i_paddr == iec_pkg::OFF_EN3 |-> (o_prdata & ~{24'h0, iec_pkg::EN3_IMPL}) == 0;
  endproperty
  a_en3_rd: assert property (p_en3_rd) else $error("enable 3 hole bits set");
  property p_pulse;
    o_core_irq |=> !o_core_irq;
  endproperty
  a_pulse: assert property (p_pulse) else $error("core request longer than one cycle");
  property p_vector;
    o_core_irq |-> o_vector_addr == iec_pkg::VECTOR_ADDR;
  endproperty
  a_vector: assert property (p_vector) else $error("wrong vector with request");
  property p_gie_off;
    wr_ctrl && !i_pwdata[7] && !i_return_from_irq ##1 !i_return_from_irq |=> !o_core_irq;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("request with global enable off");
  property p_peripheral_group_enable_off;
    wr_ctrl && !i_pwdata[6] |=> ##1 !o_wake_req;
  endproperty
  a_peripheral_group_enable_off: assert property (p_peripheral_group_enable_off) else $error("wake with group enable off");
  property p_group;
    o_core_irq |-> o_wake_req;
  endproperty
  a_group: assert property (p_group) else $error("request without group wake");
  c_take: cover property (o_core_irq);
  c_irq: cover property ($rose(o_irq));
  c_rd: cover property (rd_done && i_paddr == iec_pkg::OFF_EN3);
endmodule

bind iec_ctrl iec_ctrl_monitor i_iec_ctrl_monitor (.*);

// [bench/iec_src_model.sv]
// Model of the peripheral flag sources and the core's service routine.
`timescale 1ns/1ps
module iec_src_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_core_irq,
  input wire logic i_load,
  input wire iec_pkg::iec_bank_t i_flags,
  input wire logic [3:0] i_dly,
  output iec_pkg::iec_bank_t o_flags,
  output logic o_ret
);
  logic [3:0] cnt;
  logic busy;
  // The routine runs i_dly cycles, then clears its sources and returns in the same cycle.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flags <= '0;
      cnt <= 4'h0;
      busy <= 1'b0;
      o_ret <= 1'b0;
    end else begin
      o_ret <= 1'b0;
      if (i_load) begin
        o_flags <= i_flags;
      end
      if (i_core_irq) begin
        busy <= 1'b1;
        cnt <= i_dly;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        o_flags <= '0;
        o_ret <= 1'b1;
      end
    end
  end
endmodule

// [bench/iec_ctrl_bench.sv]
// Self-checking bench of the interrupt enable control block.
`timescale 1ns/1ps
module iec_ctrl_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pin, ret, core_irq, wake, irq, ld;
  logic take;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r, en, fl, imp;
  logic [3:0] pstrb, dly;
  logic [15:0] vec;
  iec_pkg::iec_bank_t flags, ldv;
  logic [31:0] rq[$];
  logic [31:0] vq[$];
  int err_count, checks, irq_seen, slv_seen, cyc, n, takes;
  iec_ctrl i_iec_ctrl (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_src_flags(flags), .i_ext_pin(pin),
    .i_return_from_irq(ret), .o_core_irq(core_irq), .o_vector_addr(vec), .o_wake_req(wake),
    .o_irq(irq));
  iec_src_model i_iec_src_model (.i_clk(clk), .i_rst_n(rst_n), .i_core_irq(core_irq),
    .i_load(ld), .i_flags(ldv), .i_dly(dly), .o_flags(flags), .o_ret(ret));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], ^(v & 32'h80200003)};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Holds the request until ready is sampled high, then leaves one idle cycle.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic irq_is(input logic e);
    @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  // ----------------------------------------------------------------
  // Result watcher and watchdog
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) chk(prdata, rq.pop_front());
    if (pslverr === 1'b1) slv_seen++;
    if (core_irq === 1'b1) begin
      irq_seen++;
      chk({16'h0, vec}, vq.pop_front());
    end
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      end_sim();
    end
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, pin, ld} = 6'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'hf;
    ldv = '0;
    dly = 4'h4;
    r = 32'h607857c5;
    imp = {iec_pkg::EN3_IMPL, iec_pkg::EN2_IMPL, iec_pkg::EN1_IMPL, iec_pkg::EN0_IMPL};
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(iec_pkg::OFF_CTRL, 32'h1);
    for (int i = 1; i < 5; i++) rd(8'(4 * i), 32'h0);
    rd(8'h20, 32'h0);
    chk(slv_seen, 1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'(4 * i + 4), 32'hff);
      rd(8'(4 * i + 4), {24'h0, imp[8*i +: 8]});
    end
    apb(1'b1, iec_pkg::OFF_CTRL, 32'hfe);
    rd(iec_pkg::OFF_CTRL, 32'hc0);
    for (int k = 0; k < 16; k++) begin
      en = lfsr(r);
      fl = lfsr(en);
      r = lfsr(fl);
      dly <= r[11:8] | 4'h4;
      apb(1'b1, iec_pkg::OFF_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 * i + 4), {24'h0, en[8*i +: 8]});
      ldv <= fl;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      take = r[7] && r[6] && |(fl & en & imp & 32'hfffffffe);
      if (take) vq.push_back(32'h4);
      takes += int'(take);
      n = irq_seen;
      apb(1'b1, iec_pkg::OFF_CTRL, {24'h0, r[7:6], 6'h1});
      rd(iec_pkg::OFF_CTRL, {24'h0, r[7] && !take, r[6], 6'h1});
      repeat (30) @(posedge clk);
      chk(irq_seen - n, {31'h0, take});
      rd(iec_pkg::OFF_CTRL, {24'h0, r[7:6], 6'h1});
      ldv <= '0;
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
    end
    rd(iec_pkg::OFF_STATUS, {29'h0, takes != 0, takes != 0, 1'b0});
    apb(1'b1, iec_pkg::OFF_MASK, 32'h1);
    for (int s = 1; s >= 0; s--) begin
      apb(1'b1, iec_pkg::OFF_CTRL, 32'(s));
      for (int e = 1; e >= 0; e--) begin
        pin <= 1'(e);
        repeat (4) @(posedge clk);
        rd(iec_pkg::OFF_FLAG0, 32'(e == s));
        irq_is(e == s);
        apb(1'b1, iec_pkg::OFF_MASK, 32'h0);
        irq_is(1'b0);
        apb(1'b1, iec_pkg::OFF_FLAG0, 32'h1);
        apb(1'b1, iec_pkg::OFF_STATUS, 32'h1);
        apb(1'b1, iec_pkg::OFF_MASK, 32'h1);
        irq_is(1'b0);
      end
    end
    end_sim();
  end
endmodule
